// [design/sbr_pulser.sv]
// Purpose: SCL pulse recovery for a single-master I2C port
// Assumes: pins pass two flops before use; open-drain lines, oe low drives low
// Notes:   register port: addr, wdata, write and read strobes, rdata one cycle later
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module sbr_pulser #(
  parameter int unsigned HALF_CYC = sbr_pkg::HALF_CYC
) (
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic [3:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [31:0] rdata_out,
  input  wire logic        bus_busy_flag_in,
  input  wire logic        master_mode_bit_in,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             scl_out,
  output logic             scl_oe_out,
  output logic             sda_out,
  output logic             sda_oe_out,
  output logic             irq_out
);
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic [1:0] busy_sync;
  logic [1:0] mst_sync;
  sbr_pkg::sbr_state_t  state;
  sbr_pkg::sbr_state_t  next_state;
  sbr_pkg::sbr_status_t chan_status;
  sbr_pkg::sbr_status_t dev_status;
  logic [2:0]                  result;
  logic [sbr_pkg::CNT_W-1:0]   pulse_count;
  logic [sbr_pkg::CNT_W-1:0]   pulses_left;
  logic [sbr_pkg::HALF_W-1:0]  timer;
  logic [sbr_pkg::IRQ_W-1:0]   irq_stat;
  logic [sbr_pkg::IRQ_W-1:0]   irq_mask;
  logic                        scl_drive_low;
  logic                        sda_drive_low;

  // write-one-to-clear: bits named in the write data drop; the caller ors new events back in,
  // so an event that lands in the same cycle as its clear is never lost
  function automatic logic [sbr_pkg::IRQ_W-1:0] clear_bits(
    input logic [sbr_pkg::IRQ_W-1:0] stat,
    input logic                      hit,
    input logic [31:0]               data
  );
    logic [sbr_pkg::IRQ_W-1:0] drop;
    drop = hit ? data[sbr_pkg::IRQ_W-1:0] : '0;
    return stat & ~drop;
  endfunction

  wire scl_lvl   = scl_sync[1];
  wire sda_lvl   = sda_sync[1];
  wire busy_lvl  = busy_sync[1];
  wire mst_lvl   = mst_sync[1];
  wire wr_ctrl   = wr_in && (addr_in == sbr_pkg::REG_CTRL);
  wire wr_irq    = wr_in && (addr_in == sbr_pkg::REG_IRQ);
  wire wr_mask   = wr_in && (addr_in == sbr_pkg::REG_MASK);
  wire go        = wr_ctrl && wdata_in[sbr_pkg::CTRL_GO];
  wire [sbr_pkg::CNT_W-1:0] req_count = wdata_in[sbr_pkg::CNT_W-1:0];
  wire idle      = (state == sbr_pkg::SBR_IDLE);
  wire bad_arg   = (req_count == '0);
  wire may_clock = (!busy_lvl || (mst_lvl && busy_lvl)) && scl_lvl;
  wire released  = sda_lvl;
  wire half_done = (timer == sbr_pkg::HALF_W'(HALF_CYC - 1));
  wire start_ok  = go && idle && !bad_arg && may_clock;
  wire start_blk = go && idle && !bad_arg && !may_clock;
  wire start_ok_clean = start_ok && released;
  // the last pulse went out and the line still reads low: the slave did not let go
  wire stuck_end = (state == sbr_pkg::SBR_CHECK) && !released && (pulses_left == '0);
  // a refused request never touches the line or the channel and device status; it only sets the result field and the error interrupt bit
  wire param_err = go && idle && bad_arg;
  wire ev_done   = (state == sbr_pkg::SBR_FIN);
  wire ev_err    = stuck_end || start_blk || param_err;
  wire [sbr_pkg::IRQ_W-1:0] ev_vec = {ev_err, ev_done};

  // next interrupt state in one place, shared by the sticky bits and the output line
  wire [sbr_pkg::IRQ_W-1:0] next_irq_stat = clear_bits(irq_stat, wr_irq, wdata_in) | ev_vec;
  wire [sbr_pkg::IRQ_W-1:0] next_irq_mask = wr_mask ? wdata_in[sbr_pkg::IRQ_W-1:0] : irq_mask;
  wire                      next_irq      = |(next_irq_stat & next_irq_mask);

  // state chooser kept combinational so the registered path stays short
  always_comb begin
    next_state = state;
    case (state)
      sbr_pkg::SBR_IDLE: begin
        if (start_ok && !released) begin
          next_state = sbr_pkg::SBR_LOW;
        end else if (start_ok_clean) begin
          next_state = sbr_pkg::SBR_STA;
        end
      end
      sbr_pkg::SBR_LOW: begin
        if (half_done) begin
          next_state = sbr_pkg::SBR_HIGH;
        end
      end
      sbr_pkg::SBR_HIGH: begin
        if (half_done && scl_lvl) begin
          next_state = sbr_pkg::SBR_CHECK;
        end
      end
      sbr_pkg::SBR_CHECK: begin
        if (released) begin
          next_state = sbr_pkg::SBR_STA;
        end else if (pulses_left == '0) begin
          next_state = sbr_pkg::SBR_IDLE;
        end else begin
          next_state = sbr_pkg::SBR_LOW;
        end
      end
      sbr_pkg::SBR_STA: begin
        if (half_done) begin
          next_state = sbr_pkg::SBR_STO;
        end
      end
      sbr_pkg::SBR_STO: begin
        if (half_done) begin
          next_state = sbr_pkg::SBR_FIN;
        end
      end
      sbr_pkg::SBR_FIN: begin
        next_state = sbr_pkg::SBR_IDLE;
      end
      default: begin
        next_state = sbr_pkg::SBR_IDLE;
      end
    endcase
  end

  // pins come from outside the clock domain
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scl_sync  <= 2'h3;
      sda_sync  <= 2'h3;
      busy_sync <= 2'h0;
      mst_sync  <= 2'h0;
    end else begin
      scl_sync  <= {scl_sync[0], scl_in};
      sda_sync  <= {sda_sync[0], sda_in};
      busy_sync <= {busy_sync[0], bus_busy_flag_in};
      mst_sync  <= {mst_sync[0], master_mode_bit_in};
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= sbr_pkg::SBR_IDLE;
      timer <= '0;
    end else begin
      state <= next_state;
      // the timer restarts on each phase change; in the high phase it also waits out
      // a slave stretching SCL so the high time counts from the real rise
      if (next_state != state || (state == sbr_pkg::SBR_HIGH && !scl_lvl)) begin
        timer <= '0;
      end else if (!half_done) begin
        timer <= timer + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pulse_count <= '0;
      pulses_left <= '0;
    end else begin
      if (start_ok) begin
        pulse_count <= req_count;
        pulses_left <= req_count;
      end else if (state == sbr_pkg::SBR_LOW && next_state == sbr_pkg::SBR_HIGH) begin
        pulses_left <= pulses_left - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      chan_status <= sbr_pkg::SBR_ST_READY;
      dev_status  <= sbr_pkg::SBR_ST_READY;
      result      <= sbr_pkg::RES_NONE;
    end else begin
      // only one of these can happen per cycle; the order just documents priority
      if (param_err) begin
        result <= sbr_pkg::RES_PARAM;
      end else if (start_blk) begin
        chan_status <= sbr_pkg::SBR_ST_BLOCKED;
        dev_status  <= sbr_pkg::SBR_ST_BLOCKED;
        result      <= sbr_pkg::RES_BLOCK;
      end else if (stuck_end) begin
        chan_status <= sbr_pkg::SBR_ST_SDA_LOW;
        dev_status  <= sbr_pkg::SBR_ST_SDA_LOW;
        result      <= sbr_pkg::RES_SDA;
      end else if (ev_done) begin
        chan_status <= sbr_pkg::SBR_ST_UNINIT;
        dev_status  <= sbr_pkg::SBR_ST_UNINIT;
        result      <= sbr_pkg::RES_OK;
      end
    end
  end

  // open-drain drivers: oe low means the line is pulled low
  always_comb begin
    scl_drive_low = (next_state == sbr_pkg::SBR_LOW);
    sda_drive_low = (next_state == sbr_pkg::SBR_STA);
  end

  // the enables are registered from the next state so each pin changes on the same
  // edge as the state; the data outputs stay low because the lines are open drain
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scl_out    <= 1'b0;
      scl_oe_out <= 1'b1;
    end else begin
      scl_out    <= 1'b0;
      scl_oe_out <= !scl_drive_low;
    end
  end

  // sda is only ever pulled low for the start; the stop is its release with scl high
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sda_out    <= 1'b0;
      sda_oe_out <= 1'b1;
    end else begin
      sda_out    <= 1'b0;
      sda_oe_out <= !sda_drive_low;
    end
  end

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_stat <= '0;
      irq_mask <= '0;
      irq_out  <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      // the line follows the new status and mask at once, so a mask write shows next cycle
      irq_out  <= next_irq;
    end
  end

  // read words, one per register; unmapped addresses read as zero
  wire [31:0] ctrl_word = {24'h00_0000, pulse_count};
  wire [31:0] stat_word = {20'h0_0000, !idle, result, 1'b0, chan_status, 1'b0, dev_status};
  wire [31:0] irq_word  = {30'h0000_0000, irq_stat};
  wire [31:0] mask_word = {30'h0000_0000, irq_mask};

  wire [31:0] rd_mux =
    (addr_in == sbr_pkg::REG_CTRL) ? ctrl_word :
    (addr_in == sbr_pkg::REG_STAT) ? stat_word :
    (addr_in == sbr_pkg::REG_IRQ)  ? irq_word  :
    (addr_in == sbr_pkg::REG_MASK) ? mask_word : 32'h0000_0000;

  // read data stands for exactly one cycle and is zero otherwise, so a late sample
  // by the master shows up as a wrong value rather than as stale data

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_out <= 32'h0000_0000;
    end else begin
      rdata_out <= rd_in ? rd_mux : 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// [design/sbr_pkg.sv]
// Purpose: constants shared by the bus recovery pulser
// Assumes: 25 MHz peripheral clock
// Notes:   register offsets are word addresses on the plain register port
package sbr_pkg;
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned HALF_PERIOD_NS  = 5000;
  localparam int unsigned HALF_CYC        =
    (HALF_PERIOD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned HALF_W          = 8;
  localparam int unsigned CNT_W           = 8;

  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STAT   = 4'h1;
  localparam logic [3:0] REG_IRQ    = 4'h2;
  localparam logic [3:0] REG_MASK   = 4'h3;

  localparam int unsigned CTRL_GO   = 8;
  localparam int unsigned STAT_BUSY = 3;

  localparam int unsigned IRQ_DONE  = 0;
  localparam int unsigned IRQ_ERR   = 1;
  localparam int unsigned IRQ_W     = 2;

  typedef enum logic [2:0] {
    SBR_ST_UNINIT = 3'h0,
    SBR_ST_READY  = 3'h1,
    SBR_ST_SDA_LOW = 3'h2,
    SBR_ST_BLOCKED = 3'h3
  } sbr_status_t;

  localparam logic [2:0] RES_NONE  = 3'h0;
  localparam logic [2:0] RES_OK    = 3'h1;
  localparam logic [2:0] RES_SDA   = 3'h2;
  localparam logic [2:0] RES_BLOCK = 3'h3;
  localparam logic [2:0] RES_PARAM = 3'h4;

  typedef enum logic [2:0] {
    SBR_IDLE  = 3'b000,
    SBR_LOW   = 3'b001,
    SBR_HIGH  = 3'b011,
    SBR_CHECK = 3'b010,
    SBR_STA   = 3'b110,
    SBR_STO   = 3'b111,
    SBR_FIN   = 3'b101
  } sbr_state_t;
endpackage

// [sim/sbr_pulser_sva.sv]
// Purpose: port checks for the recovery pulser
// Assumes: bus and pin inputs held steady while a recovery runs
// Notes:   low phase measured by an 8-bit counter, so any half period from 4 up to 255 cycles works
`timescale 1ns/1ns
`default_nettype none
module sbr_chk #(
  parameter int unsigned HALF_CYC = 4
) (
  input wire logic        clk_in,
  input wire logic        rst_b_in,
  input wire logic [3:0]  addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic        wr_in,
  input wire logic        bus_busy_flag_in,
  input wire logic        master_mode_bit_in,
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        scl_oe_out,
  input wire logic        sda_oe_out,
  input wire logic        irq_out
);
  logic [7:0] low_n;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) low_n <= 8'h00;
    else low_n <= scl_oe_out ? 8'h00 : low_n + 8'h01;
  end
  chk_bus_free: assert property ($fell(scl_oe_out) |->
    !$past(bus_busy_flag_in, 3) || $past(master_mode_bit_in, 3)) else $error("pulse while busy");
  chk_scl_free: assert property ($fell(scl_oe_out) |-> $past(scl_in, 3))
    else $error("pulse while scl held low");
  chk_sda_stops: assert property ($fell(scl_oe_out) |-> !$past(sda_in, 2))
    else $error("pulse after sda high");
  chk_low_time: assert property ($rose(scl_oe_out) |-> low_n >= HALF_CYC)
    else $error("scl low phase short");
  chk_high_time: assert property ($rose(scl_oe_out) |=> scl_oe_out [*3])
    else $error("scl high phase short");
  chk_start_scl_high: assert property (!sda_oe_out |-> scl_oe_out)
    else $error("sda driven while scl low");
  chk_start_stop: assert property ($fell(sda_oe_out) |=> !sda_oe_out [*3] ##[1:600] sda_oe_out)
    else $error("start without stop");
  chk_mask_off: assert property (wr_in && addr_in == sbr_pkg::REG_MASK && wdata_in[1:0] == 2'b00
    |=> !irq_out) else $error("irq while masked");
  chk_param_quiet: assert property (wr_in && addr_in == sbr_pkg::REG_CTRL && wdata_in[8] &&
    wdata_in[7:0] == 8'h00 |=> scl_oe_out [*8]) else $error("zero count pulsed");
  cover property ($fell(scl_oe_out));
  cover property ($fell(sda_oe_out));
  cover property ($rose(irq_out));
endmodule
bind sbr_pulser sbr_chk #(.HALF_CYC(HALF_CYC)) u_chk (.clk_in(clk_in), .rst_b_in(rst_b_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .bus_busy_flag_in(bus_busy_flag_in),
  .master_mode_bit_in(master_mode_bit_in), .scl_in(scl_in), .sda_in(sda_in),
  .scl_oe_out(scl_oe_out), .sda_oe_out(sda_oe_out), .irq_out(irq_out));
`default_nettype wire

// [sim/sbr_slave.sv]
// Purpose: slave that holds sda low for a set number of scl rises
// Assumes: pull-ups on both lines, release means high
// Notes:   can also hold scl low to block the pulser
`timescale 1ns/1ns
`default_nettype none
module sbr_slave (
  input  wire logic       scl_in,
  input  wire logic       arm_in,
  input  wire logic [7:0] hold_in,
  input  wire logic       scl_hold_in,
  output logic            sda_rel_out,
  output logic            scl_rel_out,
  output logic      [7:0] edges_out
);
  always @(posedge scl_in or negedge arm_in)
    if (!arm_in) edges_out <= 8'h00;
    else edges_out <= edges_out + 8'h01;
  assign sda_rel_out = !arm_in || edges_out >= hold_in;
  assign scl_rel_out = !scl_hold_in;
endmodule
`default_nettype wire

// [sim/test_scl_bus_recovery_pulser.sv]
// Purpose: self-checking bench for the recovery pulser
// Assumes: short half period of 4 cycles keeps the run brief
// Notes:   reads are checked by a monitor from a queue of notes
`timescale 1ns/1ns
`default_nettype none
module test_scl_bus_recovery_pulser;
  logic        clk_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic        rd_d = 1'b0;
  logic [3:0]  bmsa = 4'h0;
  logic [3:0]  addr_in = 4'h0;
  logic [31:0] wdata_in = 32'h0000_0000;
  logic [31:0] seed = 32'h20ac_98cb;
  logic [7:0]  hold = 8'h00;
  logic [31:0] rdata_out;
  logic [7:0]  edges;
  logic        scl_oe_out, sda_oe_out, irq_out, scl_rel, sda_rel;
  logic        scl_o, sda_o;
  wire logic   scl = scl_oe_out & scl_rel;
  wire logic   sda = sda_oe_out & sda_rel;
  int          fails = 0;
  int          compares = 0;
  int          starts, stops;
  logic [31:0] eq[$];
  string       nq[$];
  sbr_pulser #(.HALF_CYC(4)) u_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .bus_busy_flag_in(bmsa[3]), .master_mode_bit_in(bmsa[2]), .scl_in(scl), .sda_in(sda),
    .scl_out(scl_o), .scl_oe_out(scl_oe_out), .sda_out(sda_o), .sda_oe_out(sda_oe_out),
    .irq_out(irq_out));
  sbr_slave u_slave (.scl_in(scl), .arm_in(bmsa[0]), .hold_in(hold), .scl_hold_in(bmsa[1]),
    .sda_rel_out(sda_rel), .scl_rel_out(scl_rel), .edges_out(edges));
  initial forever #20 clk_in = ~clk_in;
  // start and stop are only counted when the pulser itself moves sda
  always @(negedge sda_oe_out) if (scl) starts++;
  always @(posedge sda_oe_out) if (scl) stops++;
  always @(posedge clk_in) begin
    if (rd_d) chk(nq.pop_front(), rdata_out, eq.pop_front());
    rd_d <= rd_in;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm);
    eq.push_back(e);
    nq.push_back(nm);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(posedge clk_in);
  endtask
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s;
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic logic [31:0] stw(input logic [2:0] res, input logic [2:0] st);
    return {21'h00_0000, res, 1'b0, st, 1'b0, st};
  endfunction
  // bms: busy, master, scl held low by the slave
  task automatic run(input logic [7:0] n, input logic [2:0] bms, input logic [7:0] h,
                     input logic [2:0] res, input logic [2:0] st, input logic [7:0] np);
    starts = 0;
    stops = 0;
    bmsa <= {bms, 1'b1};
    hold <= h;
    repeat (4) @(posedge clk_in);
    wr(sbr_pkg::REG_CTRL, {23'h00_0001, n});
    for (int i = 0; i < 3000 && irq_out !== 1'b1; i++) @(posedge clk_in);
    rd(sbr_pkg::REG_STAT, stw(res, st), "status");
    rd(sbr_pkg::REG_IRQ, (res == sbr_pkg::RES_OK) ? 32'h0000_0001 : 32'h0000_0002, "irq");
    chk("pulses", {24'h00_0000, edges}, {24'h00_0000, np});
    chk("starts", starts, (res == sbr_pkg::RES_OK) ? 1 : 0);
    chk("stops", stops, (res == sbr_pkg::RES_OK) ? 1 : 0);
    chk("pin_outs", {30'h0000_0000, scl_o, sda_o}, 32'h0000_0000);
    wr(sbr_pkg::REG_IRQ, 32'h0000_0003);
    rd(sbr_pkg::REG_IRQ, 32'h0000_0000, "irq_clear");
    bmsa <= 4'h0;
    repeat (4) @(posedge clk_in);
  endtask
  task automatic summarize;
    if (fails == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    logic [7:0] n;
    repeat (4) @(posedge clk_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk("scl_oe", {31'h0000_0000, scl_oe_out}, 32'h0000_0001);
    rd(sbr_pkg::REG_STAT, stw(sbr_pkg::RES_NONE, sbr_pkg::SBR_ST_READY), "stat_reset");
    rd(4'hf, 32'h0000_0000, "unmapped");
    wr(sbr_pkg::REG_MASK, 32'h0000_0003);
    rd(sbr_pkg::REG_MASK, 32'h0000_0003, "mask");
    run(8'h09, 3'b100, 8'hff, sbr_pkg::RES_BLOCK, sbr_pkg::SBR_ST_BLOCKED, 8'h00);
    run(8'h09, 3'b001, 8'hff, sbr_pkg::RES_BLOCK, sbr_pkg::SBR_ST_BLOCKED, 8'h00);
    run(8'h00, 3'b000, 8'hff, sbr_pkg::RES_PARAM, sbr_pkg::SBR_ST_BLOCKED, 8'h00);
    seed = xorshift(seed);
    n = {5'h00, seed[2:0]} + 8'h01;
    run(n, 3'b000, 8'hff, sbr_pkg::RES_SDA, sbr_pkg::SBR_ST_SDA_LOW, n);
    run(8'h09, 3'b110, 8'h05, sbr_pkg::RES_OK, sbr_pkg::SBR_ST_UNINIT, 8'h05);
    wr(sbr_pkg::REG_MASK, 32'h0000_0000);
    wr(sbr_pkg::REG_CTRL, 32'h0000_0100);
    @(posedge clk_in);
    chk("irq_masked", {31'h0000_0000, irq_out}, 32'h0000_0000);
    wr(sbr_pkg::REG_MASK, 32'h0000_0002);
    @(posedge clk_in);
    chk("irq_line", {31'h0000_0000, irq_out}, 32'h0000_0001);
    summarize();
  end
  // a few hundred cycles are needed; this bound only catches a hang
  initial begin
    #800000;
    fails++;
    summarize();
  end
endmodule
`default_nettype wire
